// file: shared/psc_pkg.sv
// Purpose: Shared constants and types for the power state coordinator
// Assumes: One core clock, synchronous active-high reset
// Notes:   Both ends import this package
package psc_pkg;

  // Core idle states, encoded by depth
  typedef enum logic [2:0] {
    PSC_C0 = 3'h0,
    PSC_C1 = 3'h1,
    PSC_C2 = 3'h2,
    PSC_C3 = 3'h3,
    PSC_C4 = 3'h4,
    PSC_C6 = 3'h6
  } psc_cstate_e;

  // Link states
  typedef enum logic [1:0] {
    PSC_L0  = 2'h0,
    PSC_L0S = 2'h1,
    PSC_L1  = 2'h3,
    PSC_L3  = 2'h2
  } psc_lstate_e;

  // System sleep states
  typedef enum logic [1:0] {
    PSC_S0 = 2'h0,
    PSC_S3 = 2'h1,
    PSC_S4 = 2'h3,
    PSC_S5 = 2'h2
  } psc_sstate_e;

  // Memory power states
  typedef enum logic [1:0] {
    PSC_M_UP   = 2'h0,
    PSC_M_PPD  = 2'h1,
    PSC_M_APD  = 2'h3,
    PSC_M_SREF = 2'h2
  } psc_mstate_e;

  // Deep power-down entry sequence
  typedef enum logic [1:0] {
    PSC_DP_IDLE  = 2'h0,
    PSC_DP_FLUSH = 2'h1,
    PSC_DP_SAVE  = 2'h3,
    PSC_DP_OFF   = 2'h2
  } psc_dp_e;

  // Number of hardware threads
  localparam int unsigned PSC_THREADS = 2;

  // Cycles spent flushing and saving context
  localparam logic [3:0] PSC_FLUSH_CYC = 4'h8;
  localparam logic [3:0] PSC_SAVE_CYC  = 4'h4;

endpackage : psc_pkg

// file: shared/psc_if.sv
// Purpose: Link between coordinator (device) and chipset (platform)
// Assumes: Both ends on core_clk_i
// Notes:   No clocking block; bench joins the ends
`timescale 1ns/1ns
interface psc_if
  import psc_pkg::*;
();
  psc_sstate_e sleep_req;   // Platform asks for sleep state
  logic        sleep_ack;   // Device has reached requested state
  psc_sstate_e sleep_state; // Sleep state the device holds
  psc_lstate_e link_req;    // Link state asked by platform
  psc_lstate_e link_state;  // Link state granted by device
  logic        wake;        // Platform wake pulse

  modport dev (
    input  sleep_req,
    input  link_req,
    input  wake,
    output sleep_ack,
    output sleep_state,
    output link_state
  );
  modport plat (
    output sleep_req,
    output link_req,
    output wake,
    input  sleep_ack,
    input  sleep_state,
    input  link_state
  );
endinterface : psc_if

// file: design/psc_dev.sv
// Contract
// - C0 runs; C1 halts with clocks on
// - C2 stops core clock, input clock runs
// - C3/C4 stop clock, lower supply
// - C6 flush, save, then cut supply
// - Threads power down independently, own storage
// - Last thread down shrinks second-level cache
// - Display supports D0 on, D3 off
// - Powerup holds CKE asserted
// - Precharge powerdown: banks closed, CKE low
// - Active powerdown: bank open, CKE low
// - Self-refresh: CKE low, memory self-refreshes
// - L0, L0s allowed in C0 to C6
// - L1 only in C2 to C4
// - L3 whenever in S3, S4, S5
// - S3 keeps memory context, clocks off
// - S3/S4: display D3, uncore off
// - Core deepens only to shallower thread request
//
// Purpose: Device end of the power state coordinator
// Assumes: Thread requests and memory inputs are on core_clk_i
// Notes:   All outputs decoded from registered state
`timescale 1ns/1ns
module psc_dev
  import psc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // Link to platform
  psc_if.dev               link,
  // Thread requests
  input  wire psc_cstate_e thr_req_i [PSC_THREADS],
  // Memory controller status
  input  wire logic        mem_idle_i,
  input  wire logic        bank_open_i,
  // Display request (1 = on)
  input  wire logic        disp_on_req_i,
  // Core state outputs
  output psc_cstate_e      core_state_o,
  output logic             core_clk_en_o,
  output logic             proc_clk_en_o,
  output logic             vcc_low_o,
  output logic             vcc_off_o,
  output logic             cache_flush_o,
  output logic             ctx_save_o,
  output logic [1:0]       thr_save_o,
  output logic             l2_shrink_o,
  // Memory and display
  output logic             cke_o,
  output psc_mstate_e      mem_state_o,
  output logic             disp_on_o,
  output logic             uncore_on_o,
  output logic             sys_clk_on_o,
  output logic             mem_ctx_keep_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    psc_cstate_e core;
    psc_dp_e     dp;
    logic [3:0]  cnt;
    logic [1:0]  tdown;
    logic [1:0]  tsave;
    logic        shrink;
    psc_sstate_e sleep;
    logic        ack;
    psc_lstate_e lnk;
    psc_mstate_e mem;
    logic        disp;
  } psc_dev_s;

  psc_dev_s st;
  psc_dev_s next_st;

  // Shallower of two idle states
  function automatic psc_cstate_e psc_min(psc_cstate_e a, psc_cstate_e b);
    return (a < b) ? a : b;
  endfunction : psc_min

  // Link state legal for given core and sleep state
  function automatic logic psc_link_ok(psc_lstate_e l, psc_cstate_e c,
                                       psc_sstate_e s);
    logic ok;
    ok = 1'b0;
    if (s != PSC_S0) begin
      ok = (l == PSC_L3);
    end else begin
      case (l)
        PSC_L0, PSC_L0S: ok = 1'b1;
        PSC_L1:          ok = (c >= PSC_C2) && (c <= PSC_C4);
        default:         ok = 1'b0;
      endcase
    end
    return ok;
  endfunction : psc_link_ok

  psc_cstate_e tgt;
  assign tgt = psc_min(thr_req_i[0], thr_req_i[1]);

  // Set while the link is being pulled out of L1 ahead of a core move
  logic lnk_drop;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.ack    = 1'b0;
    next_st.shrink = 1'b0;
    lnk_drop       = 1'b0;
    // Threads go down one by one, each into its own store
    // independent thread save
    for (int t = 0; t < PSC_THREADS; t++) begin
      next_st.tdown[t] = (thr_req_i[t] == PSC_C6);
      next_st.tsave[t] = (thr_req_i[t] == PSC_C6) && !st.tdown[t];
    end
    if (next_st.tdown == 2'b11 && st.tdown != 2'b11)
      next_st.shrink = 1'b1;

    if (st.sleep == PSC_S0) begin
      if (st.dp != PSC_DP_IDLE) begin
        // Deep power-down sequence; flush and save run to the end unless sleep is entered, a shallower thread request or a wake from sleep leaves OFF
        case (st.dp)
          PSC_DP_FLUSH: begin
            next_st.cnt = st.cnt - 4'h1;
            if (st.cnt == 4'h1) begin
              next_st.dp  = PSC_DP_SAVE;
              next_st.cnt = PSC_SAVE_CYC;
            end
          end
          PSC_DP_SAVE: begin
            next_st.cnt = st.cnt - 4'h1;
            if (st.cnt == 4'h1) begin
              next_st.dp   = PSC_DP_OFF;
              next_st.core = PSC_C6;
            end
          end
          PSC_DP_OFF: begin
            if (tgt != PSC_C6) begin
              next_st.dp   = PSC_DP_IDLE;
              next_st.core = tgt;
            end
          end
          default: next_st.dp = PSC_DP_IDLE;
        endcase
      end else if (tgt > st.core && tgt == PSC_C6) begin
        next_st.dp  = PSC_DP_FLUSH;
        next_st.cnt = PSC_FLUSH_CYC;
      end else if (tgt > st.core || link.wake || tgt < st.core) begin
        if (st.lnk != PSC_L1 || (tgt >= PSC_C2 && tgt <= PSC_C4))
          next_st.core = tgt;
        else if (tgt < st.core) begin
          next_st.lnk = PSC_L0;
          lnk_drop    = 1'b1;
        end
      end
    end

    // Sleep entry and exit
    if (link.sleep_req != st.sleep) begin
      // sleep only from core in C2 or deeper; wake returns to S0
      if (link.sleep_req == PSC_S0 || st.core >= PSC_C2 ||
          st.sleep != PSC_S0) begin
        next_st.sleep = link.sleep_req;
        next_st.ack   = 1'b1;
        if (link.sleep_req == PSC_S0) begin
          next_st.core = PSC_C0;
          next_st.dp   = PSC_DP_IDLE;
        end
      end
    end

    if (next_st.sleep != PSC_S0) begin
      next_st.lnk = PSC_L3;
    // grant only legal link states
    // A pending L1 drop must not be undone by a standing L1 ask
    end else if (lnk_drop) begin
      next_st.lnk = PSC_L0;
    end else if (psc_link_ok(link.link_req, next_st.core, next_st.sleep)) begin
      next_st.lnk = link.link_req;
    end else if (!psc_link_ok(st.lnk, next_st.core, next_st.sleep)) begin
      next_st.lnk = PSC_L0;
    end

    // Memory states
    // S3 keeps memory in self-refresh
    if (next_st.sleep != PSC_S0)
      next_st.mem = PSC_M_SREF;
    else if (next_st.core >= PSC_C3 && mem_idle_i)
      next_st.mem = PSC_M_SREF;
    else if (mem_idle_i && bank_open_i)
      next_st.mem = PSC_M_APD;
    else if (mem_idle_i)
      next_st.mem = PSC_M_PPD;
    else
      next_st.mem = PSC_M_UP;

    next_st.disp = disp_on_req_i && (next_st.sleep == PSC_S0);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st       <= '0;
      st.core  <= PSC_C0;
      st.dp    <= PSC_DP_IDLE;
      st.sleep <= PSC_S0;
      st.lnk   <= PSC_L0;
      st.mem   <= PSC_M_UP;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, decoded straight from registered state
  // ----------------------------------------------------------------
  wire logic awake = (st.sleep == PSC_S0);
  assign core_clk_en_o  = awake && (st.core <= PSC_C1) &&
                          (st.dp == PSC_DP_IDLE || st.dp == PSC_DP_FLUSH ||
                           st.dp == PSC_DP_SAVE);
  assign proc_clk_en_o  = awake && (st.core <= PSC_C2);
  // reduced supply in C3 and C4
  assign vcc_low_o      = awake && (st.core == PSC_C3 || st.core == PSC_C4);
  assign vcc_off_o      = !awake || (st.dp == PSC_DP_OFF);
  assign cache_flush_o  = (st.dp == PSC_DP_FLUSH);
  assign ctx_save_o     = (st.dp == PSC_DP_SAVE);
  assign thr_save_o     = st.tsave;
  assign l2_shrink_o    = st.shrink;
  assign cke_o          = (st.mem == PSC_M_UP);
  assign mem_state_o    = st.mem;
  assign core_state_o   = st.core;
  assign disp_on_o      = st.disp;
  assign uncore_on_o    = awake;
  assign sys_clk_on_o   = awake;
  assign mem_ctx_keep_o = (st.sleep == PSC_S3);
  assign link.sleep_ack   = st.ack;
  assign link.sleep_state = st.sleep;
  assign link.link_state  = st.lnk;

endmodule : psc_dev

// file: design/psc_plat.sv
// Purpose: Platform (chipset) end of the power state coordinator
// Assumes: User requests on core_clk_i
// Notes:   Forwards requests, asks L3 only while asking a sleep state
`timescale 1ns/1ns
module psc_plat
  import psc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // Link to device
  psc_if.plat              link,
  // User requests
  input  wire psc_sstate_e sleep_req_i,
  input  wire psc_lstate_e link_req_i,
  input  wire logic        wake_i,
  // Status
  output psc_sstate_e      sleep_state_o,
  output logic             sleep_done_o,
  output logic             sys_clk_on_o
);

  typedef struct packed {
    psc_sstate_e sreq;
    psc_lstate_e lreq;
    logic        wake;
    psc_sstate_e sst;
    logic        done;
  } psc_plat_s;

  psc_plat_s st;
  psc_plat_s next_st;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.done = link.sleep_ack;
    next_st.sst  = link.sleep_state;
    // Wake pulls the system back to S0
    next_st.wake = wake_i;
    next_st.sreq = wake_i ? PSC_S0 : sleep_req_i;
    if (next_st.sreq != PSC_S0)
      next_st.lreq = PSC_L3;
    // L3 ask while awake is sent as L0s
    else if (link_req_i == PSC_L3)
      next_st.lreq = PSC_L0S;
    else
      next_st.lreq = link_req_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st      <= '0;
      st.sreq <= PSC_S0;
      st.lreq <= PSC_L0;
      st.sst  <= PSC_S0;
    end else begin
      st <= next_st;
    end
  end

  assign link.sleep_req = st.sreq;
  assign link.link_req  = st.lreq;
  assign link.wake      = st.wake;
  assign sleep_state_o  = st.sst;
  assign sleep_done_o   = st.done;
  // clocks off except RTC when asleep
  assign sys_clk_on_o   = (st.sst == PSC_S0);

endmodule : psc_plat

// file: verif/psc_asserts.sv
// Purpose: Concurrent checks on the link between the two ends
// Assumes: One clock, synchronous active-high reset
// Notes:   Sees only interface signals, so core state is not used
`timescale 1ns/1ns
module psc_asserts
  import psc_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        srst_i,
  // Link signals
  input wire psc_sstate_e sleep_req,
  input wire logic        sleep_ack,
  input wire psc_sstate_e sleep_state,
  input wire psc_lstate_e link_req,
  input wire psc_lstate_e link_state,
  input wire logic        wake
);
  // ------------------------------------------------------------
  // Link properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  AST_L3_WHEN_ASLEEP: assert property (
    sleep_state != PSC_S0 |-> link_state == PSC_L3)
    else $error("link not off while asleep");
  AST_ENTRY_WITH_ACK: assert property (
    $changed(sleep_state) && sleep_state != PSC_S0 |-> sleep_ack)
    else $error("sleep entry without ack");
  AST_ACK_MATCHES_REQ: assert property (
    sleep_ack |-> sleep_state == $past(sleep_req))
    else $error("ack for a state not asked");
  AST_ENTRY_AS_ASKED: assert property (
    $changed(sleep_state) && sleep_state != PSC_S0
      |-> $past(sleep_req) == sleep_state)
    else $error("sleep state not the one asked");
  AST_SLEEP_HOLDS: assert property (
    sleep_state != PSC_S0 && sleep_state == sleep_req && !wake
      |=> $stable(sleep_state))
    else $error("sleep state left without cause");
  // link moves only to asked or safe states
  AST_LINK_MOVES_LEGAL: assert property (
    $changed(link_state) |-> link_state == $past(link_req)
      || link_state inside {PSC_L0, PSC_L3})
    else $error("link moved to a state not asked");
  // light link state only when asked
  AST_L0S_ONLY_ASKED: assert property (
    $changed(link_state) && link_state == PSC_L0S
      |-> $past(link_req) == PSC_L0S)
    else $error("light link state not asked");
  // light link states granted while awake once asked steadily for three cycles
  AST_LOW_LINK_GRANTED: assert property (
    (sleep_state == PSC_S0 && link_req inside {PSC_L0, PSC_L0S})[*3]
      ##0 $stable(link_req) |-> link_state == link_req)
    else $error("light link state refused");
endmodule : psc_asserts

// file: verif/power_state_coordinator_tb.sv
// Purpose: Self-checking bench joining device and platform ends
// Assumes: Both ends on one 250 MHz clock
// Notes:   Memory powerdown is checked in C2 only, though also chosen in C0 and C1
`timescale 1ns/1ns
module power_state_coordinator_tb
  import psc_pkg::*;
;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic        core_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  psc_cstate_e thr [PSC_THREADS];
  psc_sstate_e sreq, pst;
  psc_lstate_e lreq;
  psc_cstate_e cst;
  psc_mstate_e mst;
  logic        idle, bopen, dreq, wk, cen, pen, vlo, voff, fl, sv, shr;
  logic        cke, don, unc, sclk, keep, sdone, pclk;
  logic [1:0]  tsv;
  int          n_mismatch = 0;
  int          total_checks = 0;

  // Free-running clock
  always #2 core_clk_i = ~core_clk_i;

  psc_if link ();
  psc_dev psc_dev_i (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .link(link), .thr_req_i(thr), .mem_idle_i(idle),
    .bank_open_i(bopen), .disp_on_req_i(dreq), .core_state_o(cst),
    .core_clk_en_o(cen), .proc_clk_en_o(pen), .vcc_low_o(vlo),
    .vcc_off_o(voff), .cache_flush_o(fl), .ctx_save_o(sv),
    .thr_save_o(tsv), .l2_shrink_o(shr), .cke_o(cke), .mem_state_o(mst),
    .disp_on_o(don), .uncore_on_o(unc), .sys_clk_on_o(sclk),
    .mem_ctx_keep_o(keep));
  psc_plat psc_plat_i (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .link(link), .sleep_req_i(sreq), .link_req_i(lreq), .wake_i(wk),
    .sleep_state_o(pst), .sleep_done_o(sdone), .sys_clk_on_o(pclk));
  psc_asserts psc_asserts_i (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .sleep_req(link.sleep_req), .sleep_ack(link.sleep_ack),
    .sleep_state(link.sleep_state), .link_req(link.link_req),
    .link_state(link.link_state), .wake(link.wake));

  // Flag comparison
  task automatic chk_flag(string nm, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask : chk_flag

  // State or count comparison
  task automatic chk_val(string nm, logic [3:0] e, logic [3:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk_val

  task automatic step(int n);
    repeat (n) @(posedge core_clk_i);
  endtask : step

  // Single place where the run ends
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  // Hang guard, far beyond the expected run of about 500 cycles
  initial begin
    #20000;
    n_mismatch++;
    conclude();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    psc_cstate_e a, b, c;
    psc_lstate_e lt;
    psc_sstate_e s;
    int unsigned r;
    int k, nf, ns, n0, n1, nl, on;
    thr = '{PSC_C0, PSC_C0};
    idle = 1'b0;
    bopen = 1'b0;
    dreq = 1'b1;
    wk = 1'b0;
    sreq = PSC_S0;
    lreq = PSC_L0;
    r = $urandom(38);
    step(3);
    srst_i <= 1'b0;
    // Random thread pairs; first pair is a corner with one thread in C4
    for (int i = 0; i < 40; i++) begin
      a = psc_cstate_e'($urandom_range(4, 0));
      b = (i == 0) ? PSC_C4 : psc_cstate_e'($urandom_range(4, 0));
      lt = psc_lstate_e'($urandom_range(3, 0));
      if (lt == PSC_L3) lt = PSC_L1;
      lreq <= PSC_L0;
      step(3);
      thr <= '{a, b};
      idle <= 1'($urandom);
      bopen <= 1'($urandom);
      dreq <= 1'($urandom);
      step(3);
      lreq <= lt;
      step(4);
      @(negedge core_clk_i);
      c = (a < b) ? a : b;
      chk_val("core", c, cst);
      chk_flag("core_clk", c <= PSC_C1, cen);
      chk_flag("proc_clk", c <= PSC_C2, pen);
      chk_flag("vcc_low", c inside {PSC_C3, PSC_C4}, vlo);
      chk_flag("disp", dreq, don);
      if (lt == PSC_L1 && !(c inside {PSC_C2, PSC_C3, PSC_C4})) lt = PSC_L0;
      chk_val("link", lt, link.link_state);
      if (!idle) begin
        chk_val("mem", PSC_M_UP, mst);
        chk_flag("cke", 1'b1, cke);
      end else if (c >= PSC_C3) begin
        chk_val("mem", PSC_M_SREF, mst);
        chk_flag("cke", 1'b0, cke);
      end else if (c == PSC_C2) begin
        chk_val("mem", bopen ? PSC_M_APD : PSC_M_PPD, mst);
        chk_flag("cke", 1'b0, cke);
      end
    end
    $display("test core_link done");
    // Staggered deep power-down entry, then exit
    @(posedge core_clk_i);
    thr <= '{PSC_C0, PSC_C0};
    nf = 0;
    ns = 0;
    n0 = 0;
    n1 = 0;
    nl = 0;
    on = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge core_clk_i);
      if (k == 4) thr[0] <= PSC_C6;
      if (k == 7) thr[1] <= PSC_C6;
      @(negedge core_clk_i);
      if (voff === 1'b1 && on == 0) begin
        on = 1;
        chk_val("flush_cycles", PSC_FLUSH_CYC, 4'(nf));
        chk_val("save_cycles", PSC_SAVE_CYC, 4'(ns));
      end
      nf += int'(fl);
      ns += int'(sv);
      n0 += int'(tsv[0]);
      n1 += int'(tsv[1]);
      nl += int'(shr);
    end
    chk_flag("vcc_off", 1'b1, voff);
    chk_val("thr0_save", 4'h1, 4'(n0));
    chk_val("thr1_save", 4'h1, 4'(n1));
    chk_val("l2_shrink", 4'h1, 4'(nl));
    @(posedge core_clk_i);
    thr <= '{PSC_C0, PSC_C0};
    step(4);
    @(negedge core_clk_i);
    chk_val("c6_exit", PSC_C0, cst);
    $display("test deep_powerdown done");
    // Sleep refused in C0, then each sleep state entered and left
    @(posedge core_clk_i);
    sreq <= PSC_S3;
    dreq <= 1'b1;
    step(6);
    @(negedge core_clk_i);
    chk_val("refused", PSC_S0, pst);
    for (int j = 0; j < 3; j++) begin
      s = (j == 0) ? PSC_S3 : (j == 1) ? PSC_S4 : PSC_S5;
      @(posedge core_clk_i);
      sreq <= PSC_S0;
      thr <= '{PSC_C2, PSC_C2};
      step(4);
      sreq <= s;
      k = 0;
      do begin
        @(negedge core_clk_i);
        k++;
      end while (sdone !== 1'b1 && k < 20);
      chk_flag("done", 1'b1, sdone);
      chk_val("sleep", s, pst);
      chk_val("link_off", PSC_L3, link.link_state);
      chk_flag("sys_clk", 1'b0, sclk);
      chk_flag("plat_clk", 1'b0, pclk);
      chk_flag("ctx_keep", s == PSC_S3, keep);
      chk_flag("cke_sleep", 1'b0, cke);
      if (s != PSC_S5) chk_flag("disp_off", 1'b0, don);
      if (s != PSC_S5) chk_flag("uncore", 1'b0, unc);
      @(posedge core_clk_i);
      wk <= 1'b1;
      // Drop the sleep ask with the wake, or the core falls straight back
      sreq <= PSC_S0;
      @(posedge core_clk_i);
      wk <= 1'b0;
      k = 0;
      do begin
        @(negedge core_clk_i);
        k++;
      end while (pst !== PSC_S0 && k < 20);
      repeat (3) @(negedge core_clk_i);
      chk_val("woke", PSC_S0, pst);
      chk_flag("clk_back", 1'b1, sclk);
    end
    $display("test sleep done");
    conclude();
  end
endmodule : power_state_coordinator_tb
